// [cce_pkg.sv]
package cce_pkg;
    // APB byte addresses of the register words
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_CLEAR   = 8'h08;
    localparam logic [7:0] ADDR_ENABLE  = 8'h0C;
    localparam logic [7:0] ADDR_AVAIL   = 8'h10;

    // Control register field positions
    localparam int BIT_ON      = 15;
    localparam int BIT_OE      = 14;
    localparam int BIT_INV     = 13;
    localparam int BIT_EVT     = 9;
    localparam int BIT_RES     = 8;
    localparam int BIT_EDGE_HI = 7;
    localparam int BIT_EDGE_LO = 6;
    localparam int BIT_REF     = 4;
    localparam int BIT_CH_HI   = 1;
    localparam int BIT_CH_LO   = 0;

    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // Bits that software may write (event flag handled separately)
    localparam logic [15:0] CTRL_WMASK = 16'hE0D3;

    // Status / interrupt bit positions
    localparam int ST_EVENT = 0;
    localparam int ST_TOGGLE = 1;
    localparam int ST_W = 2;

    // Edge select encodings
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_ANY  = 2'h3;

    // Default availability: every channel and the reference present
    localparam logic [4:0] AVAIL_RESET = 5'h1F;
endpackage

// [cce_top.sv]
`timescale 1ns/100ps
module cce_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        cmp_raw_i,
    output logic             cmp_enable_o,
    output logic             ref_sel_o,
    output logic      [1:0]  chan_sel_o,
    output logic             ref_gnd_o,
    output logic             chan_gnd_o,
    output logic             comparator_output_pin_o,
    output logic             comparator_output_pin_oe_o,
    output logic             trigger_o,
    output logic             irq_o
);
    logic [15:0]        ctrl_reg;
    logic [15:0]        ctrl_next;
    logic               res_reg;
    logic               prev_reg;
    logic               flag_reg;
    logic               flag_next;
    logic [cce_pkg::ST_W-1:0] stat_reg;
    logic [cce_pkg::ST_W-1:0] stat_next;
    logic [cce_pkg::ST_W-1:0] ien_reg;
    logic [4:0]         avail_reg;
    logic [31:0]        rdata_reg;
    logic               ready_reg;
    logic               err_reg;
    logic               trig_reg;
    logic               irq_reg;
    logic               pin_reg;
    logic               pin_oe_reg;
    logic               on_reg;
    logic               refs_reg;
    logic [1:0]         chs_reg;
    logic               refg_reg;
    logic               chg_reg;

    // APB decode; access phase completes with zero wait states
    wire        setup_w   = psel_i && !penable_i;
    wire        wr_w      = setup_w && pwrite_i;
    wire        rd_w      = setup_w && !pwrite_i;
    wire        hit_ctrl  = paddr_i == cce_pkg::ADDR_CTRL;
    wire        hit_stat  = paddr_i == cce_pkg::ADDR_STATUS;
    wire        hit_clr   = paddr_i == cce_pkg::ADDR_CLEAR;
    wire        hit_en    = paddr_i == cce_pkg::ADDR_ENABLE;
    wire        hit_av    = paddr_i == cce_pkg::ADDR_AVAIL;
    wire        mapped_w  = hit_ctrl || hit_stat || hit_clr || hit_en || hit_av;
    wire        wr_ctrl   = wr_w && hit_ctrl;
    wire        wr_lo     = wr_ctrl && pstrb_i[0];
    wire        wr_hi     = wr_ctrl && pstrb_i[1];
    wire [15:0] lane_mask = {{8{wr_hi}}, {8{wr_lo}}};

    // Control fields
    wire        on_w    = ctrl_reg[cce_pkg::BIT_ON];
    wire        oe_w    = ctrl_reg[cce_pkg::BIT_OE];
    wire        inv_w   = ctrl_reg[cce_pkg::BIT_INV];
    wire [1:0]  edge_w  = ctrl_reg[cce_pkg::BIT_EDGE_HI:cce_pkg::BIT_EDGE_LO];
    wire        ref_w   = ctrl_reg[cce_pkg::BIT_REF];
    wire [1:0]  ch_w    = ctrl_reg[cce_pkg::BIT_CH_HI:cce_pkg::BIT_CH_LO];

    // Polarity-adjusted result; held low while the comparator is off
    wire        adj_w   = on_w && (cmp_raw_i ^ inv_w);
    wire        rise_w  = adj_w && !prev_reg;
    wire        fall_w  = !adj_w && prev_reg;
    wire        hit_edge_w = (edge_w == cce_pkg::EDGE_ANY  && (rise_w || fall_w))
                      || (edge_w == cce_pkg::EDGE_FALL && fall_w)
                      || (edge_w == cce_pkg::EDGE_RISE && rise_w);
    // Blocked while the flag stands, so one event per software clear
    wire        event_w = on_w && hit_edge_w && !flag_reg;
    // Change status is also held off while the flag stands, so no interrupt slips past it
    wire        toggle_w = on_w && (rise_w || fall_w) && !flag_reg;

    // Flag clear by writing zero; a simultaneous event wins
    wire        flag_clr = wr_hi && !pwdata_i[cce_pkg::BIT_EVT];
    assign flag_next = event_w ? 1'b1 : (flag_clr ? 1'b0 : flag_reg);

    // Writable fields only; unimplemented bits never stored
    assign ctrl_next = (ctrl_reg & ~(cce_pkg::CTRL_WMASK & lane_mask))
                     | (pwdata_i[15:0] & cce_pkg::CTRL_WMASK & lane_mask);

    // Sticky interrupt status; set beats write-one-to-clear
    wire [cce_pkg::ST_W-1:0] ev_vec = {toggle_w, event_w};
    wire [cce_pkg::ST_W-1:0] clr_vec = (wr_w && hit_clr && pstrb_i[0])
                                     ? pwdata_i[cce_pkg::ST_W-1:0]
                                     : {cce_pkg::ST_W{1'b0}};
    assign stat_next = ev_vec | (stat_reg & ~clr_vec);

    // Selected input missing on this package: ground it
    wire        ref_gnd_w = !avail_reg[4] && ref_w;
    wire        ch_gnd_w  = !avail_reg[ch_w];

    // Read view of the control word
    wire [15:0] ctrl_view = {ctrl_reg[15:13], 3'h0, flag_reg, res_reg,
                             ctrl_reg[7:6], 1'h0, ctrl_reg[4], 2'h0,
                             ctrl_reg[1:0]};
    wire [31:0] rd_mux =
        hit_ctrl ? {16'h0000, ctrl_view} :
        hit_stat ? {{(32-cce_pkg::ST_W){1'b0}}, stat_reg} :
        hit_en   ? {{(32-cce_pkg::ST_W){1'b0}}, ien_reg} :
        hit_av   ? {27'h0000000, avail_reg} : 32'h00000000;

    // Control and flag storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= cce_pkg::CTRL_RESET;
            flag_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            flag_reg <= flag_next;
        end
    end

    // Latched result and edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_reg  <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            res_reg  <= adj_w;
            prev_reg <= adj_w;
        end
    end

    // Interrupt status, enable and package availability
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_reg  <= '0;
            ien_reg   <= '0;
            avail_reg <= cce_pkg::AVAIL_RESET;
        end else begin
            stat_reg <= stat_next;
            if (wr_w && hit_en && pstrb_i[0]) begin
                ien_reg <= pwdata_i[cce_pkg::ST_W-1:0];
            end
            if (wr_w && hit_av && pstrb_i[0]) begin
                avail_reg <= pwdata_i[4:0];
            end
        end
    end

    // APB answer registered in setup so it stands through access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h00000000;
            ready_reg <= 1'b0;
            err_reg   <= 1'b0;
        end else begin
            ready_reg <= setup_w;
            err_reg   <= setup_w && !mapped_w;
            rdata_reg <= rd_w ? rd_mux : 32'h00000000;
        end
    end

    // Analog-side and pin outputs, all registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            on_reg     <= 1'b0;
            refs_reg   <= 1'b0;
            chs_reg    <= 2'h0;
            refg_reg   <= 1'b0;
            chg_reg    <= 1'b0;
            pin_reg    <= 1'b0;
            pin_oe_reg <= 1'b0;
            trig_reg   <= 1'b0;
            irq_reg    <= 1'b0;
        end else begin
            on_reg     <= on_w;
            refs_reg   <= ref_w;
            chs_reg    <= ch_w;
            refg_reg   <= ref_gnd_w;
            chg_reg    <= ch_gnd_w;
            pin_reg    <= oe_w && adj_w;
            pin_oe_reg <= oe_w;
            trig_reg   <= event_w;
            irq_reg    <= |(stat_next & ien_reg);
        end
    end

    assign prdata_o                   = rdata_reg;
    assign pready_o                   = ready_reg;
    assign pslverr_o                  = err_reg;
    assign cmp_enable_o               = on_reg;
    assign ref_sel_o                  = refs_reg;
    assign chan_sel_o                 = chs_reg;
    assign ref_gnd_o                  = refg_reg;
    assign chan_gnd_o                 = chg_reg;
    assign comparator_output_pin_o    = pin_reg;
    assign comparator_output_pin_oe_o = pin_oe_reg;
    assign trigger_o                  = trig_reg;
    assign irq_o                      = irq_reg;
endmodule // cce_top

// [cce_core.sv]
`timescale 1ns/100ps
// Comparator core: a grounded input reads as level zero
module cce_core (
    input  wire logic       en_i,
    input  wire logic [3:0] pos_i,
    input  wire logic [3:0] neg_i,
    input  wire logic       ref_gnd_i,
    input  wire logic       chan_gnd_i,
    output logic            raw_o
);
    // Held low while off; no hysteresis, so equal levels give 0
    assign raw_o = en_i && ((ref_gnd_i ? 4'h0 : pos_i) > (chan_gnd_i ? 4'h0 : neg_i));
endmodule // cce_core

// [cce_props.sv]
`timescale 1ns/100ps
module cce_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        cmp_enable_o,
    input wire logic        comparator_output_pin_o,
    input wire logic        comparator_output_pin_oe_o,
    input wire logic        trigger_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Setup cycle of a control write
    wire ctl_wr = psel_i && !penable_i && pwrite_i && paddr_i == cce_pkg::ADDR_CTRL;
    ready_after_a: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready");
    ready_once_a: assert property (pready_o |=> !pready_o) else $error("ready held");
    err_ready_a: assert property (pslverr_o |-> pready_o) else $error("stray error");
    idle_data_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("stray data");
    run_bit_a: assert property (ctl_wr |-> ##2 cmp_enable_o == $past(pwdata_i[15], 2))
        else $error("enable wrong");
    pin_en_a: assert property (ctl_wr |-> ##2 comparator_output_pin_oe_o == $past(pwdata_i[14], 2))
        else $error("pin enable wrong");
    pin_quiet_a: assert property (!comparator_output_pin_oe_o |-> !comparator_output_pin_o)
        else $error("pin driven");
    trig_pulse_a: assert property (trigger_o |=> !trigger_o) else $error("long trigger");
    trig_hold_a: assert property (trigger_o && !psel_i ##1 !psel_i [*2] |-> !trigger_o)
        else $error("trigger while flagged");
    irq_drop_a: assert property ($fell(irq_o) |-> $past(psel_i && pwrite_i)) else $error("irq fell");
    cover property (trigger_o);
    cover property (pslverr_o);
    cover property ($fell(irq_o));
endmodule // cce_props

bind cce_top cce_props u_props (.*);

// [cce_top_tb.sv]
`timescale 1ns/100ps
module cce_top_tb;
    localparam logic [7:0] CT = cce_pkg::ADDR_CTRL;
    localparam logic [7:0] AV = cce_pkg::ADDR_AVAIL;
    localparam logic [7:0] CL = cce_pkg::ADDR_CLEAR;
    logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, cmp_raw_i, se;
    logic cmp_enable_o, ref_sel_o, ref_gnd_o, chan_gnd_o, trigger_o, irq_o;
    logic comparator_output_pin_o, comparator_output_pin_oe_o;
    logic [31:0] pwdata_i, prdata_o, rd, c;
    logic [7:0]  paddr_i;
    logic [3:0]  pstrb_i, pos, neg;
    logic [1:0]  chan_sel_o;
    int          fails, tests_run, trg, cyc, t0;
    cce_top dut (.*);
    cce_core u_core (.en_i(cmp_enable_o), .pos_i(pos), .neg_i(neg), .ref_gnd_i(ref_gnd_o),
                     .chan_gnd_i(chan_gnd_o), .raw_o(cmp_raw_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Trigger count; the cycle ceiling cuts a hang short
    always @(posedge clk_i) begin
        cyc++;
        if (trigger_o === 1'b1) trg++;
        if (cyc == 3000) begin
            fails++;
            wrap_up();
        end
    end
    // One APB transfer; waits for ready without assuming a latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        se = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        // Idle cycle so the next call never drives psel twice in one step
        @(posedge clk_i);
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    // Edge then settle, counting triggers across it
    task automatic edge_cnt(input logic [3:0] p, input int e, input string s);
        t0 = trg;
        pos <= p;
        repeat (4) @(posedge clk_i);
        chk(s, e, trg - t0);
    endtask
    task automatic t_regs;
        apb(0, CT, 32'h0);
        chk("ctrl reset", {16'h0, cce_pkg::CTRL_RESET}, rd);
        apb(0, AV, 32'h0);
        chk("avail reset", 32'h1F, rd);
        apb(1, CT, 32'hFFFF);
        apb(0, CT, 32'h0);
        chk("ctrl all", 32'hE3D3, rd);
        chk("pin", 32'h3, {comparator_output_pin_o, comparator_output_pin_oe_o});
        chk("sel", 32'hF, {cmp_enable_o, ref_sel_o, chan_sel_o});
        apb(1, CT, 32'h0);
        @(posedge clk_i);
        chk("off", 32'h0, {cmp_enable_o, comparator_output_pin_oe_o});
        $display("done regs");
    endtask
    task automatic t_edges;
        for (int m = 0; m < 4; m++) begin
            for (int v = 0; v < 2; v++) begin
                c = {16'h0, 2'b10, v[0], 5'h0, m[1:0], 6'h0};
                apb(1, CT, c);
                apb(1, CT, c);
                edge_cnt(4'h1, m == 3 || (m == 1 && v == 0) || (m == 2 && v == 1), "rise");
                apb(1, CT, c);
                edge_cnt(4'h0, m == 3 || (m == 1 && v == 1) || (m == 2 && v == 0), "fall");
            end
        end
        // Last fall above left the flag set; rearm before the hold test
        apb(1, CT, c);
        edge_cnt(4'h1, 1, "first");
        edge_cnt(4'h0, 0, "held");
        edge_cnt(4'h1, 0, "held");
        $display("done edges");
    endtask
    task automatic t_irq;
        apb(1, cce_pkg::ADDR_ENABLE, 32'h0);
        apb(1, CT, 32'h80C0);
        // Polarity switch above may itself set the flag; clear it again
        apb(1, CT, 32'h80C0);
        apb(1, CL, 32'h3);
        edge_cnt(4'h0, 1, "irq edge");
        apb(0, cce_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h3, rd);
        chk("masked", 32'h0, {31'h0, irq_o});
        apb(1, cce_pkg::ADDR_ENABLE, 32'h1);
        @(posedge clk_i);
        chk("irq on", 32'h1, {31'h0, irq_o});
        apb(1, CL, 32'h1);
        @(posedge clk_i);
        chk("irq off", 32'h0, {31'h0, irq_o});
        apb(0, 8'h20, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], se});
        $display("done irq");
    endtask
    task automatic t_gnd;
        apb(1, CT, 32'h0013);
        apb(1, AV, 32'h17);
        @(posedge clk_i);
        chk("chan gnd", 32'h1, {ref_gnd_o, chan_gnd_o});
        apb(1, AV, 32'h0F);
        @(posedge clk_i);
        chk("ref gnd", 32'h2, {ref_gnd_o, chan_gnd_o});
        $display("done gnd");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        {rst_i, psel_i, penable_i, pwrite_i} = 4'h8;
        {paddr_i, pwdata_i, pos, neg} = 48'h0;
        pstrb_i = 4'hF;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_edges();
        t_irq();
        t_gnd();
        wrap_up();
    end
endmodule // cce_top_tb
